// File: design/ewd_decode.sv
// Behaviour
// - Footnoted MOV, BIT, CMP rows one cycle less
// - Extended instruction operands are 20 bits wide
// - Accept prefix word; run unprefixed extended ops
// - Register layout only for register-mode forms
// - Words 1800h to 1FFFh are extension words
// - Zero-carry clear uses current carry flag
// - Zero-carry set feeds zero carry in
// - Count from bits 3:0 when source clear
// - Count from register low bits when set
// - Count field holds repetitions minus one
// - A/L with B/W selects data length
// - Non-register word supplies operand upper nibbles
//
// Extension word decoder top: watches the fetch stream, holds a prefix
// word and issues decoded controls with the following instruction.
// Assumes fetch and datapath share clk; count register value arrives
// combinationally from the register file in the same cycle.
// A second extension word that meets a held prefix is issued as the
// following instruction; prefixes never stack.
// Decode sits in front of one register stage: a cycle of latency is
// traded for outputs that all leave flip-flops.
`timescale 1ns/1ps
module ewd_decode #(
  parameter int CNT_W = ewd_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fetchValid,
  input wire logic [ewd_pkg::WORD_W-1:0] fetchWord,
  input wire logic nativeExt,
  input wire logic carryFlag,
  input wire logic [CNT_W-1:0] countRegValue,
  input wire logic [2:0] tableCycles,
  input wire logic footnoted,
  output logic [ewd_pkg::CNT_W-1:0] countRegSel,
  output logic instValid,
  output logic [ewd_pkg::WORD_W-1:0] instOut,
  output ewd_pkg::ewd_ctrl_t ctrlOut,
  output logic carryIn,
  output logic [2:0] execCycles
);

  typedef enum logic {
    EWD_IDLE,
    EWD_HELD
  } ewd_state_t;

  function automatic logic cycleSave(input logic [ewd_pkg::WORD_W-1:0] w);
    logic [3:0] op;
    op = w[ewd_pkg::F1_OPC_HI:ewd_pkg::F1_OPC_LO];
    cycleSave = (op == ewd_pkg::OPC_MOV) | (op == ewd_pkg::OPC_CMP) |
                (op == ewd_pkg::OPC_BIT);
  endfunction

  // controls of an extended op that runs without a prefix
  function automatic ewd_pkg::ewd_ctrl_t nativeControls();
    ewd_pkg::ewd_ctrl_t c;
    c = '0;
    c.extended = 1'b1;
    // Address-word length and 20-bit operands; no repeat, no carry change
    c.dataLen = ewd_pkg::EWD_LEN_ADDR;
    c.wide20 = 1'b1;
    nativeControls = c;
  endfunction

  ewd_state_t state_reg, state_next;
  logic [ewd_pkg::WORD_W-1:0] ext_reg;
  logic [ewd_pkg::CNT_W-1:0] countRegSel_reg;
  logic instValid_reg;
  logic [ewd_pkg::WORD_W-1:0] inst_reg;
  ewd_pkg::ewd_ctrl_t ctrl_reg;
  logic carryIn_reg;
  logic [2:0] cyc_reg;

  wire logic isExt;
  assign isExt = fetchWord[ewd_pkg::OPC_HI:ewd_pkg::OPC_LO] == ewd_pkg::EXT_OPC;

  // Prefix capture: an extension word seen while nothing is held
  wire logic takePrefix;
  assign takePrefix = fetchValid & isExt & (state_reg == EWD_IDLE);

  // Field decode of the held prefix against the word now fetched
  wire ewd_pkg::ewd_ctrl_t fieldCtrl;
  ewd_field ewd_field_i (
    .extWord(ext_reg),
    .instWord(fetchWord),
    .regLowBits(countRegValue[ewd_pkg::CNT_W-1:0]),
    .ctrl(fieldCtrl)
  );

  // Controls for the word being issued now
  wire logic issue;
  wire logic prefixed;
  wire ewd_pkg::ewd_ctrl_t nativeCtrl;
  wire ewd_pkg::ewd_ctrl_t issueCtrl;
  wire logic carryNext;
  assign issue = fetchValid & ~takePrefix;
  assign prefixed = state_reg == EWD_HELD;
  assign nativeCtrl = nativeControls();
  // native extended ops get 20-bit width without a prefix
  assign issueCtrl = prefixed ? fieldCtrl : (nativeExt ? nativeCtrl : '0);
  assign carryNext = issueCtrl.carryForceZero ? 1'b0 : carryFlag;

  // Cycle count handed to the datapath, from the table and the opcode
  wire logic isFmt1;
  wire logic saveOne;
  wire logic canCut;
  wire logic [2:0] cycNext;
  assign isFmt1 = fetchWord[ewd_pkg::F1_OPC_HI:ewd_pkg::F1_OPC_LO] >= ewd_pkg::F1_FIRST;
  assign saveOne = footnoted & isFmt1 & cycleSave(fetchWord);
  // Never cut below one cycle, whatever the caller's table says
  assign canCut = tableCycles > ewd_pkg::CYC_ONE;
  assign cycNext = (saveOne & canCut) ? (tableCycles - ewd_pkg::CYC_ONE) : tableCycles;

  // Prefix held until the next fetched word arrives
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EWD_IDLE: begin
        if (fetchValid && isExt) begin
          state_next = EWD_HELD;
        end
      end
      EWD_HELD: begin
        // A second prefix here is issued as the instruction
        if (fetchValid) begin
          state_next = EWD_IDLE;
        end
      end
      default: state_next = EWD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= EWD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Prefix word kept for the field decoder until its partner arrives;
  // gaps in the fetch stream leave it untouched
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_reg <= '0;
    end else if (takePrefix) begin
      ext_reg <= fetchWord;
    end
  end

  // Register select is registered so the register file read has a cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      countRegSel_reg <= '0;
    end else if (takePrefix) begin
      countRegSel_reg <= fetchWord[ewd_pkg::CNT_HI:ewd_pkg::CNT_LO];
    end
  end

  // Issue pulse: one cycle per word handed to the datapath
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instValid_reg <= 1'b0;
    end else begin
      instValid_reg <= issue;
    end
  end

  // Issued word holds until the next issue
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inst_reg <= '0;
    end else if (issue) begin
      inst_reg <= fetchWord;
    end
  end

  // Decoded controls travel with the issued word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
    end else if (issue) begin
      ctrl_reg <= issueCtrl;
    end
  end

  // Carry input sampled with the issued word; a later flag change
  // belongs to the next instruction, not to this one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carryIn_reg <= 1'b0;
    end else if (issue) begin
      carryIn_reg <= carryNext;
    end
  end

  // Cycle count for the issued word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= '0;
    end else if (issue) begin
      cyc_reg <= cycNext;
    end
  end

  // Outputs straight from the issue-stage flip-flops
  assign countRegSel = countRegSel_reg;
  assign instValid = instValid_reg;
  assign instOut = inst_reg;
  assign ctrlOut = ctrl_reg;
  assign carryIn = carryIn_reg;
  assign execCycles = cyc_reg;

endmodule

// File: design/ewd_pkg.sv
// Package for the extension word decoder: field positions, opcode range,
// data length codes, cycle-table constants and the carrier structs.
// Assumes 16-bit instruction words fetched in program order.
package ewd_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 20;
  localparam int CNT_W = 4;

  // Opcode range of an extension word, seen in bits 15:11
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 11;
  localparam logic [4:0] EXT_OPC = 5'h03;

  // Register-mode field positions
  localparam int ZC_BIT = 8;
  localparam int REP_BIT = 7;
  localparam int AL_BIT = 6;
  localparam int CNT_HI = 3;
  localparam int CNT_LO = 0;

  // Non-register-mode field positions
  localparam int SRCX_HI = 10;
  localparam int SRCX_LO = 7;
  localparam int DSTX_HI = 3;
  localparam int DSTX_LO = 0;

  // Byte/word bit and addressing fields of the following instruction
  localparam int BW_BIT = 6;
  localparam int AS_HI = 5;
  localparam int AS_LO = 4;
  localparam int AD_BIT = 7;
  localparam int F1_OPC_HI = 15;
  localparam int F1_OPC_LO = 12;
  localparam int F2_OPC_HI = 15;
  localparam int F2_OPC_LO = 10;
  localparam logic [5:0] F2_OPC = 6'h04;
  localparam logic [1:0] AS_REG = 2'h0;

  // Format I opcodes that take one cycle less on footnoted entries
  localparam logic [3:0] OPC_MOV = 4'h4;
  localparam logic [3:0] OPC_CMP = 4'h9;
  localparam logic [3:0] OPC_BIT = 4'hb;
  localparam logic [3:0] F1_FIRST = 4'h4;

  // Footnoted rows are those with an indexed, symbolic or absolute dest
  localparam logic [2:0] CYC_ONE = 3'h1;

  typedef enum logic [1:0] {
    EWD_LEN_RSVD,
    EWD_LEN_ADDR,
    EWD_LEN_WORD,
    EWD_LEN_BYTE
  } ewd_len_t;

  // Decoded controls handed to the datapath with the next instruction
  typedef struct packed {
    logic extended;
    logic regMode;
    logic carryForceZero;
    logic repFromReg;
    logic [CNT_W-1:0] countRegister;
    logic [CNT_W:0] repCount;
    logic [CNT_W-1:0] srcUpper;
    logic [CNT_W-1:0] dstUpper;
    ewd_len_t dataLen;
    logic wide20;
  } ewd_ctrl_t;

endpackage

// File: design/ewd_field.sv
// Field extraction from one extension word together with the
// instruction word that follows it. Purely combinational.
// Assumes the caller only trusts the result when the word is extended.
`timescale 1ns/1ps
module ewd_field (
  input wire logic [ewd_pkg::WORD_W-1:0] extWord,
  input wire logic [ewd_pkg::WORD_W-1:0] instWord,
  input wire logic [ewd_pkg::CNT_W-1:0] regLowBits,
  output ewd_pkg::ewd_ctrl_t ctrl
);

  // Register layout: Format I reg/reg, or Format II register mode
  wire logic isFmt2;
  wire logic srcReg;
  wire logic dstReg;
  wire logic regMode;
  assign isFmt2 = instWord[ewd_pkg::F2_OPC_HI:ewd_pkg::F2_OPC_LO] == ewd_pkg::F2_OPC;
  assign srcReg = instWord[ewd_pkg::AS_HI:ewd_pkg::AS_LO] == ewd_pkg::AS_REG;
  assign dstReg = ~instWord[ewd_pkg::AD_BIT];
  assign regMode = isFmt2 ? srcReg : (srcReg & dstReg);

  // Count source and the stored n-1 offset
  wire logic repFromReg;
  wire logic [ewd_pkg::CNT_W-1:0] cntField;
  wire logic [ewd_pkg::CNT_W-1:0] cntRaw;
  assign repFromReg = extWord[ewd_pkg::REP_BIT];
  assign cntField = extWord[ewd_pkg::CNT_HI:ewd_pkg::CNT_LO];
  assign cntRaw = repFromReg ? regLowBits : cntField;

  // Length from A/L and B/W
  wire logic [1:0] lenPair;
  assign lenPair = {extWord[ewd_pkg::AL_BIT], instWord[ewd_pkg::BW_BIT]};

  // reserved bits 5:4 are never looked at; 10:9 only as srcUpper in non-register mode
  always_comb begin
    ctrl = '0;
    ctrl.extended = 1'b1;
    ctrl.regMode = regMode;
    ctrl.carryForceZero = regMode & extWord[ewd_pkg::ZC_BIT];
    ctrl.repFromReg = regMode & repFromReg;
    ctrl.countRegister = cntField;
    ctrl.repCount = regMode ? ({1'b0, cntRaw} + 5'h01) : 5'h01;
    ctrl.srcUpper = regMode ? 4'h0 : extWord[ewd_pkg::SRCX_HI:ewd_pkg::SRCX_LO];
    ctrl.dstUpper = regMode ? 4'h0 : extWord[ewd_pkg::DSTX_HI:ewd_pkg::DSTX_LO];
    ctrl.dataLen = ewd_pkg::ewd_len_t'(lenPair);
    ctrl.wide20 = 1'b1;
  end

endmodule

// File: bench/ewd_decode_sva.sv
// Checker on the ports of the extension word decoder.
// Assumes one clock domain and inputs that change off the rising edge.
`timescale 1ns/1ps
module ewd_decode_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  input wire logic carryFlag,
  input wire logic [3:0] countRegValue,
  input wire logic [3:0] countRegSel,
  input wire logic instValid,
  input wire logic [15:0] instOut,
  input wire ewd_pkg::ewd_ctrl_t ctrlOut,
  input wire logic carryIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic pend;
  wire isExt = fetchValid && fetchWord[15:11] == ewd_pkg::EXT_OPC;
  // Mirror of the held prefix; a second prefix is issued, not held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pend <= 1'b0;
    else if (fetchValid) pend <= isExt && !pend;
  end
  ext_hold_a: assert property (isExt && !pend |=> !instValid)
    else $error("prefix word was issued");
  issue_now_a: assert property (
    fetchValid && !(isExt && !pend) |=> instValid && instOut == $past(fetchWord))
    else $error("word not issued next cycle");
  wide_ops_a: assert property (
    instValid && $past(pend) |-> ctrlOut.extended && ctrlOut.wide20)
    else $error("prefixed word not wide");
  carry_zero_a: assert property (instValid && ctrlOut.carryForceZero |-> !carryIn)
    else $error("carry not forced to zero");
  carry_pass_a: assert property (
    instValid && !ctrlOut.carryForceZero |-> carryIn == $past(carryFlag))
    else $error("carry flag not passed");
  rep_field_a: assert property (
    instValid && $past(pend) && ctrlOut.regMode && !ctrlOut.repFromReg
    |-> ctrlOut.repCount == {1'b0, countRegSel} + 5'h01) else $error("field count wrong");
  rep_reg_a: assert property (
    instValid && $past(pend) && ctrlOut.regMode && ctrlOut.repFromReg
    |-> ctrlOut.repCount == {1'b0, $past(countRegValue)} + 5'h01) else $error("reg count wrong");
  nonreg_once_a: assert property (
    instValid && $past(pend) && !ctrlOut.regMode
    |-> ctrlOut.repCount == 5'h01 && !ctrlOut.carryForceZero) else $error("non-reg count wrong");
  cover property (instValid && ctrlOut.repFromReg);
  cover property (instValid && $past(pend) && !ctrlOut.regMode);
  cover property (instValid && ctrlOut.carryForceZero);
endmodule

// File: bench/ewd_fetch_model.sv
// Program memory model feeding the fetch port from a queue of words.
// Assumes the bench pushes entries; bit 16 of an entry marks a gap.
`timescale 1ns/1ps
module ewd_fetch_model (
  input wire logic clk,
  output logic fetchValid,
  output logic [15:0] fetchWord
);
  logic [16:0] prog[$];
  logic [16:0] ent;
  initial begin
    fetchValid = 1'b0;
    fetchWord = 16'h0000;
  end
  // Idle words are inverted so a stale value never passes for data
  always @(negedge clk) begin
    ent = (prog.size() > 0) ? prog.pop_front() : 17'h10000;
    fetchValid <= !ent[16];
    fetchWord <= ent[16] ? ~fetchWord : ent[15:0];
  end
endmodule

// File: bench/ewd_decode_tb_top.sv
// Self-checking bench for the extension word decoder.
// Assumes the program memory model is the only fetch source.
`timescale 1ns/1ps
module ewd_decode_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic nativeExt = 1'b0, carryFlag = 1'b1, footnoted = 1'b0;
  logic fetchValid, instValid, carryIn;
  logic [15:0] fetchWord, instOut;
  logic [3:0] countRegValue, countRegSel;
  logic [2:0] tableCycles = 3'h4, execCycles;
  ewd_pkg::ewd_ctrl_t ctrlOut;
  int n_fail = 0, cmp_count = 0;
  always #4 clk = ~clk;
  // Register file stand-in: each register number reads back different low bits
  assign countRegValue = countRegSel ^ 4'h6;
  ewd_fetch_model ewd_fetch_model_i (.clk, .fetchValid, .fetchWord);
  ewd_decode ewd_decode_i (.clk, .arst_n, .fetchValid, .fetchWord, .nativeExt, .carryFlag,
    .countRegValue, .tableCycles, .footnoted, .countRegSel, .instValid, .instOut, .ctrlOut,
    .carryIn, .execCycles);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Queue words, then wait a bounded time for the issue pulse
  task automatic run(input logic [16:0] w[$]);
    int k;
    foreach (w[i]) ewd_fetch_model_i.prog.push_back(w[i]);
    @(negedge clk);
    for (k = 0; k < 20 && instValid !== 1'b1; k++) @(negedge clk);
    if (k == 20) begin
      n_fail++;
      finish_test();
    end
  endtask
  // Top count with reserved bits set, then a register count across a gap
  task automatic t_count;
    run('{17'h01e7f, 17'h04548});
    check("rep", ctrlOut.repCount, 5'h10);
    check("cin", carryIn, 1'b1);
    check("mode", ctrlOut.regMode, 1'b1);
    run('{17'h019c5, 17'h10000, 17'h10000, 17'h01105});
    check("rrep", ctrlOut.repCount, 5'h04);
    check("zc", carryIn, 1'b0);
    check("sel", countRegSel, 4'h5);
    check("inst", instOut, 16'h1105);
    check("creg", ctrlOut.countRegister, 4'h5);
    check("rsrc", ctrlOut.repFromReg, 1'b1);
    run('{17'h01fff, 17'h04548});
    check("top", instOut, 16'h4548);
    check("trep", ctrlOut.repCount, 5'h0a);
    run('{17'h01800, 17'h01840});
    check("pp", instOut, 16'h1840);
    run('{17'h017ff});
    check("n17", instOut, 16'h17ff);
  endtask
  task automatic t_nonreg;
    carryFlag = 1'b0;
    run('{17'h01d05, 17'h04558});
    check("nmode", ctrlOut.regMode, 1'b0);
    check("src", ctrlOut.srcUpper, 4'ha);
    check("dst", ctrlOut.dstUpper, 4'h5);
    check("w20", ctrlOut.wide20, 1'b1);
    check("ncin", carryIn, 1'b0);
    carryFlag = 1'b1;
  endtask
  task automatic t_len;
    for (int i = 0; i < 4; i++) begin
      run('{i[1] ? 17'h01840 : 17'h01800, i[0] ? 17'h04548 : 17'h04508});
      check("len", ctrlOut.dataLen, i[1:0]);
    end
  endtask
  // Unprefixed words, native extended ops and the footnoted cycle cut
  task automatic t_plain;
    logic [3:0] ops[4] = '{4'h4, 4'h9, 4'hb, 4'h5};
    run('{17'h04508});
    check("ext0", ctrlOut.extended, 1'b0);
    nativeExt = 1'b1;
    run('{17'h04508});
    check("ext1", ctrlOut.extended, 1'b1);
    nativeExt = 1'b0;
    footnoted = 1'b1;
    foreach (ops[i]) begin
      run('{{1'b0, ops[i], 12'h508}});
      check("cyc", execCycles, (ops[i] == 4'h5) ? 3'h4 : 3'h3);
    end
    footnoted = 1'b0;
    run('{17'h04508});
    check("cyc0", execCycles, 3'h4);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_count();
    t_nonreg();
    t_len();
    t_plain();
    finish_test();
  end
endmodule
bind ewd_decode ewd_decode_sva ewd_decode_sva_i (.clk, .arst_n, .fetchValid, .fetchWord,
  .carryFlag, .countRegValue, .countRegSel, .instValid, .instOut, .ctrlOut, .carryIn);
